// ### hw/pacc_pkg.sv
package pacc_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    // Printed offsets are word indices; the byte address is four times that.
    localparam logic [7:0] PACC_FLAG_IDX = 8'h25;
    localparam logic [7:0] PACC_CTRL_IDX = 8'h26;
    localparam logic [7:0] PACC_CNT_IDX = 8'h27;
    localparam int PACC_ADDR_W = 10;
    localparam logic [9:0] PACC_FLAG_ADDR = {PACC_FLAG_IDX, 2'b00};
    localparam logic [9:0] PACC_CTRL_ADDR = {PACC_CTRL_IDX, 2'b00};
    localparam logic [9:0] PACC_CNT_ADDR = {PACC_CNT_IDX, 2'b00};

    // =====================================================================
    // Control register fields
    // =====================================================================
    localparam int PACC_CTRL_ENABLE_BIT = 6;
    localparam int PACC_CTRL_MODE_BIT = 5;
    localparam int PACC_CTRL_EDGE_BIT = 4;
    localparam int PACC_CTRL_CAPSEL_BIT = 2;
    localparam int PACC_CTRL_RATE_LSB = 0;
    localparam logic [7:0] PACC_CTRL_MASK = 8'h77;
    localparam logic [7:0] PACC_CTRL_RESET = 8'h00;

    // =====================================================================
    // Flag register fields
    // =====================================================================
    localparam int PACC_FLAG_PERIODIC_BIT = 6;
    localparam int PACC_FLAG_WRAP_BIT = 5;
    localparam int PACC_FLAG_EDGE_BIT = 4;
    localparam logic [2:0] PACC_FLAG_RESET = 3'h0;

    // =====================================================================
    // Timebase
    // =====================================================================
    localparam int PACC_GATE_DIV_LOG2 = 6;
    localparam int PACC_PERIODIC_BASE_LOG2 = 13;
    localparam int PACC_PERIODIC_MAX_LOG2 = 16;

    // =====================================================================
    // Bus answers and register decode
    // =====================================================================
    localparam logic [1:0] PACC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PACC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PACC_SEL_NONE,
        PACC_SEL_FLAG,
        PACC_SEL_CTRL,
        PACC_SEL_CNT
    } pacc_reg_type;

endpackage

// ### hw/pacc_tick_if.sv
`timescale 1ns/100ps
interface pacc_tick_if;
    logic [1:0] rateSel;
    logic gateTick;
    logic periodTimeout;

    modport ctrl (
        output rateSel,
        input gateTick,
        input periodTimeout
    );

    modport timer (
        input rateSel,
        output gateTick,
        output periodTimeout
    );
endinterface

// ### hw/pacc_timebase.sv
`timescale 1ns/100ps
module pacc_timebase
    import pacc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    pacc_tick_if.timer tick
);

    // =====================================================================
    // Free-running divider chain
    // =====================================================================
    // One chain serves both taps, so the periodic interval is measured from
    // the previous timeout and never from a flag clear.
    logic [PACC_PERIODIC_MAX_LOG2-1:0] divCount_q;
    logic [PACC_PERIODIC_MAX_LOG2-1:0] divCount_d;
    logic [PACC_PERIODIC_MAX_LOG2-1:0] periodMask;

    function automatic logic [PACC_PERIODIC_MAX_LOG2-1:0] rate_mask(input logic [1:0] sel);
        logic [PACC_PERIODIC_MAX_LOG2:0] one;
        one = {{PACC_PERIODIC_MAX_LOG2{1'b0}}, 1'b1};
        rate_mask = PACC_PERIODIC_MAX_LOG2'((one << (PACC_PERIODIC_BASE_LOG2 + int'(sel))) - 1);
    endfunction

    always_comb begin
        divCount_d = divCount_q + 1'b1;
        periodMask = rate_mask(tick.rateSel);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            divCount_q <= '0;
        end else begin
            divCount_q <= divCount_d;
        end
    end

    assign tick.gateTick = &divCount_q[PACC_GATE_DIV_LOG2-1:0];
    assign tick.periodTimeout = (divCount_q & periodMask) == periodMask;

endmodule

// ### hw/pacc_top.sv
// Contract
// - One 8-bit counter, event or gated mode.
// - Event mode counts qualifying input transitions.
// - Gated mode counts clock/64 while input active.
// - Enable bit one enables, zero disables.
// - Mode bit one gated, zero event.
// - Event mode, edge bit zero: falling edge.
// - Event mode, edge bit one: rising edge.
// - Gated, edge bit zero: count while high.
// - Gated, edge bit one: count while low.
// - Selector gives channel to capture or compare.
// - Control bits 7 and 3 read zero.
// - Periodic timebase is clock divided by 2^13.
// - Counter unaffected by reset, always readable/writable.
// - Gated count readable while input inactive.
// - Reads never see a partial count update.
// - Wrap flag on rollover; write one clears.
// - Edge flag on selected edge; write one clears.
// - Periods 2^13 to 2^16 cycles by rate code.
// - Period restarts at timeout, never at clear.
`timescale 1ns/100ps
module pacc_top
    import pacc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic countInputPin,
    input wire logic [PACC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [PACC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic capture4Enable,
    output logic compare5Enable
);

    // =====================================================================
    // Register decode
    // =====================================================================
    function automatic pacc_reg_type decode_reg(input logic [PACC_ADDR_W-1:0] addr);
        case (addr)
            PACC_FLAG_ADDR: decode_reg = PACC_SEL_FLAG;
            PACC_CTRL_ADDR: decode_reg = PACC_SEL_CTRL;
            PACC_CNT_ADDR: decode_reg = PACC_SEL_CNT;
            default: decode_reg = PACC_SEL_NONE;
        endcase
    endfunction

    // =====================================================================
    // Timebase
    // =====================================================================
    pacc_tick_if tick ();

    pacc_timebase u_timebase (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick.timer)
    );

    // =====================================================================
    // State declarations
    // =====================================================================
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [2:0] flags_q;
    logic [2:0] flags_d;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic pinPrev_q;
    logic pinPrev_d;

    logic awHeld_q;
    logic awHeld_d;
    logic [PACC_ADDR_W-1:0] awAddr_q;
    logic [PACC_ADDR_W-1:0] awAddr_d;
    logic wHeld_q;
    logic wHeld_d;
    logic [31:0] wData_q;
    logic [31:0] wData_d;
    logic wLowLane_q;
    logic wLowLane_d;
    logic bValid_q;
    logic bValid_d;
    logic [1:0] bResp_q;
    logic [1:0] bResp_d;
    logic rValid_q;
    logic rValid_d;
    logic [31:0] rData_q;
    logic [31:0] rData_d;
    logic [1:0] rResp_q;
    logic [1:0] rResp_d;

    logic enable;
    logic gatedMode;
    logic edgeCtrl;
    logic riseSeen;
    logic fallSeen;
    logic selectedEdge;
    logic gateActive;
    logic countStep;
    logic wrapEvent;
    logic commitWrite;
    pacc_reg_type writeSel;
    pacc_reg_type readSel;
    logic [7:0] writeByte;

    assign enable = ctrl_q[PACC_CTRL_ENABLE_BIT];
    assign gatedMode = ctrl_q[PACC_CTRL_MODE_BIT];
    assign edgeCtrl = ctrl_q[PACC_CTRL_EDGE_BIT];
    assign tick.rateSel = ctrl_q[PACC_CTRL_RATE_LSB +: 2];

    // =====================================================================
    // Bus write path
    // =====================================================================
    // Address and data are taken independently; the register update happens
    // on the edge after both are held, together with the write response.
    always_comb begin
        awHeld_d = awHeld_q;
        awAddr_d = awAddr_q;
        wHeld_d = wHeld_q;
        wData_d = wData_q;
        wLowLane_d = wLowLane_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        commitWrite = awHeld_q && wHeld_q && !bValid_q;
        writeSel = decode_reg(awAddr_q);
        writeByte = wData_q[7:0];
        if (s_axi_awvalid && !awHeld_q) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeld_q) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wLowLane_d = s_axi_wstrb[0];
        end
        if (commitWrite) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = (writeSel == PACC_SEL_NONE) ? PACC_RESP_SLVERR : PACC_RESP_OKAY;
        end else if (bValid_q && s_axi_bready) begin
            bValid_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
            wHeld_q <= 1'b0;
            wData_q <= 32'h0;
            wLowLane_q <= 1'b0;
            bValid_q <= 1'b0;
            bResp_q <= PACC_RESP_OKAY;
        end else begin
            awHeld_q <= awHeld_d;
            awAddr_q <= awAddr_d;
            wHeld_q <= wHeld_d;
            wData_q <= wData_d;
            wLowLane_q <= wLowLane_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
        end
    end

    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready = !wHeld_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;

    // =====================================================================
    // Pulse accumulator counting
    // =====================================================================
    always_comb begin
        pinPrev_d = countInputPin;
        riseSeen = countInputPin && !pinPrev_q;
        fallSeen = !countInputPin && pinPrev_q;
        selectedEdge = edgeCtrl ? riseSeen : fallSeen;
        gateActive = edgeCtrl ? !countInputPin : countInputPin;
        // A gated step needs both the clock/64 tick and an open gate.
        if (gatedMode) begin
            countStep = enable && tick.gateTick && gateActive;
        end else begin
            countStep = enable && selectedEdge;
        end
        wrapEvent = countStep && (count_q == 8'hff);
        count_d = count_q;
        if (commitWrite && wLowLane_q && writeSel == PACC_SEL_CNT) begin
            count_d = writeByte;
        end else if (countStep) begin
            count_d = count_q + 8'h01;
        end
    end

    // The count holds its value across reset by design.
    always_ff @(posedge mclk) begin
        count_q <= count_d;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pinPrev_q <= pinPrev_d;
        end else begin
            pinPrev_q <= pinPrev_d;
        end
    end

    // =====================================================================
    // Control and flag registers
    // =====================================================================
    always_comb begin
        ctrl_d = ctrl_q;
        flags_d = flags_q;
        if (commitWrite && wLowLane_q) begin
            if (writeSel == PACC_SEL_CTRL) begin
                ctrl_d = writeByte & PACC_CTRL_MASK;
            end
            if (writeSel == PACC_SEL_FLAG) begin
                flags_d = flags_q & ~{writeByte[PACC_FLAG_PERIODIC_BIT],
                    writeByte[PACC_FLAG_WRAP_BIT], writeByte[PACC_FLAG_EDGE_BIT]};
            end
        end
        // Hardware sets after the clear so a same-cycle event is kept.
        if (tick.periodTimeout) begin
            flags_d[2] = 1'b1;
        end
        if (wrapEvent) begin
            flags_d[1] = 1'b1;
        end
        if (enable && selectedEdge) begin
            flags_d[0] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_q <= PACC_CTRL_RESET;
            flags_q <= PACC_FLAG_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            flags_q <= flags_d;
        end
    end

    assign capture4Enable = ctrl_q[PACC_CTRL_CAPSEL_BIT];
    assign compare5Enable = !ctrl_q[PACC_CTRL_CAPSEL_BIT];

    // =====================================================================
    // Bus read path
    // =====================================================================
    // The count is sampled from its register in a single edge, so a read
    // cannot catch a half-updated value.
    always_comb begin
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        readSel = decode_reg(s_axi_araddr);
        if (s_axi_arvalid && !rValid_q) begin
            rValid_d = 1'b1;
            rResp_d = PACC_RESP_OKAY;
            case (readSel)
                PACC_SEL_FLAG: begin
                    rData_d = {24'h0, 1'b0, flags_q, 4'h0};
                end
                PACC_SEL_CTRL: begin
                    rData_d = {24'h0, ctrl_q & PACC_CTRL_MASK};
                end
                PACC_SEL_CNT: begin
                    rData_d = {24'h0, count_q};
                end
                default: begin
                    rData_d = 32'h0;
                    rResp_d = PACC_RESP_SLVERR;
                end
            endcase
        end else if (rValid_q && s_axi_rready) begin
            rValid_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rValid_q <= 1'b0;
            rData_q <= 32'h0;
            rResp_q <= PACC_RESP_OKAY;
        end else begin
            rValid_q <= rValid_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
        end
    end

    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;

endmodule

// ### tb/pacc_chk.sv
`timescale 1ns/100ps
module pacc_chk
    import pacc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [PACC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture4Enable,
    input wire logic compare5Enable
);
    // ==========================================================
    // Address of the read in flight
    // ==========================================================
    logic [PACC_ADDR_W-1:0] rdAddr_q;
    logic mapped;
    always_ff @(posedge mclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rdAddr_q <= s_axi_araddr;
        end
    end
    assign mapped = rdAddr_q == PACC_FLAG_ADDR || rdAddr_q == PACC_CTRL_ADDR
        || rdAddr_q == PACC_CNT_ADDR;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_sel_excl;
        compare5Enable == !capture4Enable;
    endproperty
    property p_ctrl_rsvd;
        s_axi_rvalid && rdAddr_q == PACC_CTRL_ADDR |-> s_axi_rdata[31:8] == 24'h0
            && !s_axi_rdata[7] && !s_axi_rdata[3];
    endproperty
    property p_flag_rsvd;
        s_axi_rvalid && rdAddr_q == PACC_FLAG_ADDR |-> s_axi_rdata[3:0] == 4'h0;
    endproperty
    property p_unmapped;
        s_axi_rvalid && !mapped |-> s_axi_rresp == PACC_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    property p_mapped_ok;
        s_axi_rvalid && mapped |-> s_axi_rresp == PACC_RESP_OKAY;
    endproperty
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_wr_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty

    a_sel_excl: assert property (p_sel_excl) else $error("selector outputs clash");
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control spare bits set");
    a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag spare bits set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped read refused");
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");

    c_cnt_read: cover property (s_axi_rvalid && rdAddr_q == PACC_CNT_ADDR);
    c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == PACC_RESP_SLVERR);
    c_capture: cover property (capture4Enable);
endmodule

bind pacc_top pacc_chk u_pacc_chk (.mclk(mclk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .capture4Enable(capture4Enable), .compare5Enable(compare5Enable));

// ### tb/pacc_pin_model.sv
`timescale 1ns/100ps
module pacc_pin_model (
    input wire logic mclk,
    input wire logic wantLevel,
    output logic countInputPin
);
    logic changed_q = 1'b0;
    initial countInputPin = 1'b1;
    // Two changes are never on adjacent edges, so the pin toggles at half the clock at most.
    always @(posedge mclk) begin
        if (!changed_q && countInputPin != wantLevel) begin
            countInputPin <= wantLevel;
            changed_q <= 1'b1;
        end else begin
            changed_q <= 1'b0;
        end
    end
endmodule

// ### tb/pacc_top_tb.sv
`timescale 1ns/100ps
module pacc_top_tb
    import pacc_pkg::*;
;
    logic mclk, sys_rst, wantLevel, countInputPin, cap4En, cmp5En, tA, tD, aDone, dDone;
    logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
    logic [PACC_ADDR_W-1:0] awAddr, arAddr;
    logic [31:0] wData, rData, lastData, rng;
    logic [3:0] wStrb;
    logic [1:0] bResp, rResp, lastResp, rs;
    logic [7:0] mCnt;
    int error_cnt, checks, cyc, n, t0, t1, tr, per;

    pacc_top u_pacc_top (.mclk(mclk), .sys_rst(sys_rst), .countInputPin(countInputPin),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .capture4Enable(cap4En), .compare5Enable(cmp5En));
    pacc_pin_model u_pacc_pin_model (.mclk(mclk), .wantLevel(wantLevel),
        .countInputPin(countInputPin));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ==========================================================
    // Reporting
    // ==========================================================
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            final_report();
        end
    end

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // ==========================================================
    // Bus master; ready is sampled at the falling edge before the taking edge
    // ==========================================================
    task automatic wr(input logic [PACC_ADDR_W-1:0] a, input logic [7:0] d);
        awAddr <= a;
        wData <= {24'h0, d};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        aDone = 1'b0;
        dDone = 1'b0;
        while (!(aDone && dDone)) begin
            @(negedge mclk);
            tA = awValid && awReady;
            tD = wValid && wReady;
            @(posedge mclk);
            if (tA) begin
                awValid <= 1'b0;
                aDone = 1'b1;
            end
            if (tD) begin
                wValid <= 1'b0;
                dDone = 1'b1;
            end
        end
        do begin
            @(negedge mclk);
            tA = bValid;
            rs = bResp;
            @(posedge mclk);
        end while (!tA);
        bReady <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [PACC_ADDR_W-1:0] a);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(negedge mclk);
            tA = arReady;
            @(posedge mclk);
        end while (!tA);
        arValid <= 1'b0;
        do begin
            @(negedge mclk);
            tA = rValid;
            lastData = rData;
            lastResp = rResp;
            @(posedge mclk);
        end while (!tA);
        rReady <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rdc(input logic [PACC_ADDR_W-1:0] a, input logic [31:0] m, exp);
        rd(a);
        check(lastData & m, exp);
    endtask

    task automatic pulses(input int k);
        repeat (k) begin
            wantLevel <= 1'b0;
            repeat (2) @(posedge mclk);
            wantLevel <= 1'b1;
            repeat (2) @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
    endtask

    task automatic wait_flag(output int t);
        do begin
            rd(PACC_FLAG_ADDR);
        end while (!lastData[PACC_FLAG_PERIODIC_BIT]);
        t = cyc;
    endtask

    initial begin
        {sys_rst, wantLevel, wStrb} = {2'b11, 4'hf};
        {awValid, wValid, bReady, arValid, rReady} = 5'h0;
        {awAddr, arAddr, wData} = '0;
        {rng, cyc, error_cnt, checks} = {32'h0000000f, 96'h0};
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        tr = cyc;
        check(cmp5En, 32'h1);
        rdc(PACC_CTRL_ADDR, 32'hffffffff, 32'h0);
        wr(PACC_CTRL_ADDR, 8'hff);
        rdc(PACC_CTRL_ADDR, 32'hffffffff, 32'h77);
        check({cap4En, cmp5En}, 32'h2);
        wr(10'h000, 8'h55);
        check(rs, PACC_RESP_SLVERR);
        rdc(10'h000, 32'hffffffff, 32'h0);
        for (int e = 0; e < 2; e++) begin
            wr(PACC_CTRL_ADDR, e ? 8'h50 : 8'h40);
            wr(PACC_FLAG_ADDR, 8'h30);
            mCnt = 8'(xs());
            wr(PACC_CNT_ADDR, mCnt);
            n = int'(xs() % 8) + 1;
            pulses(n);
            mCnt = mCnt + 8'(n);
            rdc(PACC_CNT_ADDR, 32'hff, mCnt);
            rdc(PACC_FLAG_ADDR, 32'h10, 32'h10);
        end
        wr(PACC_CNT_ADDR, 8'hff);
        wr(PACC_FLAG_ADDR, 8'h30);
        pulses(1);
        rdc(PACC_CNT_ADDR, 32'hff, 32'h0);
        rdc(PACC_FLAG_ADDR, 32'h30, 32'h30);
        wr(PACC_FLAG_ADDR, 8'h30);
        rdc(PACC_FLAG_ADDR, 32'h30, 32'h0);
        wr(PACC_CTRL_ADDR, 8'h00);
        wr(PACC_CNT_ADDR, 8'h3c);
        pulses(3);
        rdc(PACC_CNT_ADDR, 32'hff, 32'h3c);
        rdc(PACC_FLAG_ADDR, 32'h30, 32'h0);
        for (int e = 0; e < 2; e++) begin
            wr(PACC_CTRL_ADDR, e ? 8'h70 : 8'h60);
            wantLevel <= e[0];
            repeat (8) @(posedge mclk);
            wr(PACC_CNT_ADDR, 8'h00);
            wantLevel <= !e[0];
            repeat (3 << PACC_GATE_DIV_LOG2) @(posedge mclk);
            wantLevel <= e[0];
            repeat (8) @(posedge mclk);
            rdc(PACC_CNT_ADDR, 32'hff, 32'h3);
        end
        wantLevel <= 1'b1;
        wr(PACC_CNT_ADDR, 8'h5a);
        sys_rst <= 1'b1;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        tr = cyc;
        rdc(PACC_CNT_ADDR, 32'hff, 32'h5a);
        rdc(PACC_CTRL_ADDR, 32'hff, 32'h0);
        for (int r = 0; r < 2; r++) begin
            per = 1 << (PACC_PERIODIC_BASE_LOG2 + r);
            wr(PACC_CTRL_ADDR, 8'(r));
            wr(PACC_FLAG_ADDR, 8'h40);
            wait_flag(t0);
            if (r == 0) begin
                check(32'(t0 - tr >= per - 10 && t0 - tr <= per + 10), 32'h1);
            end
            repeat (2000) @(posedge mclk);
            wr(PACC_FLAG_ADDR, 8'h40);
            wait_flag(t1);
            check(32'(t1 - t0 >= per - 10 && t1 - t0 <= per + 10), 32'h1);
        end
        final_report();
    end
endmodule
